/* File: rrf_exec.sv */
// What this block does
// - Rotate-through-carry shifts right, old bit 0 goes to carry, old carry to bit 7.
// - Rotate-through-carry decodes from upper nibbles 0011 then 00da, low byte address.
// - Rotate-through-carry updates carry, negative and zero only.
// - Destination bit 0 sends the result to the accumulator, 1 to the file register.
// - Bank bit 0 uses the fixed access bank, 1 uses the bank select register.
// - Plain rotate (0100 then 00da) shifts right and copies old bit 0 to bit 7.
// - Plain rotate updates negative and zero, carry keeps its value.
// - Fill (0110 then 100a) writes FFh to the file register and alters no flag.
// - Each instruction is one word in one cycle: decode, read, process, write phases.
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module rrf_exec (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Instruction in
    input  wire logic        instrValid,
    input  wire logic [15:0] instrWord,
    input  wire logic [3:0]  bankSelectReg,
    // File register port
    output logic      [11:0] fileAddr,
    output logic             fileRead,
    input  wire logic [7:0]  fileRdata,
    output logic             fileWrite,
    output logic      [7:0]  fileWdata,
    // Results and flags
    output logic      [7:0]  accReg,
    output logic             carryFlag,
    output logic             negFlag,
    output logic             zeroFlag,
    output logic             busy,
    output logic             done,
    output logic             illegal
);
    // Sequencer state
    rrf_pkg::rrf_phase_e phaseReg;
    rrf_pkg::rrf_phase_e phaseNext;
    rrf_pkg::rrf_op_e    opReg;
    rrf_pkg::rrf_op_e    decodedOp;
    logic [15:0]         instrHoldReg;
    logic                takeInstr;
    logic                rejectInstr;
    logic                inWrite;

    // Datapath state
    logic [11:0]         fileAddrNext;
    logic [7:0]          operandReg;
    logic [7:0]          resultReg;
    logic [7:0]          resultNext;
    logic                newCarryReg;
    logic                newCarryNext;
    logic                destFile;
    logic                rotateOp;
    logic                resultIsZero;

    // Combinational opcode decode
    always_comb begin
        decodedOp = rrf_pkg::OP_NONE;
        if (instrWord[rrf_pkg::HI_NIB_MSB:rrf_pkg::HI_NIB_LSB] == rrf_pkg::OP_HI_RRC &&
            instrWord[rrf_pkg::ROT_SEL_MSB:rrf_pkg::ROT_SEL_LSB] == rrf_pkg::OP_LO_ROT) begin
            decodedOp = rrf_pkg::OP_RRC;
        end else if (instrWord[rrf_pkg::HI_NIB_MSB:rrf_pkg::HI_NIB_LSB] == rrf_pkg::OP_HI_RRN &&
            instrWord[rrf_pkg::ROT_SEL_MSB:rrf_pkg::ROT_SEL_LSB] == rrf_pkg::OP_LO_ROT) begin
            decodedOp = rrf_pkg::OP_RRN;
        end else if (instrWord[rrf_pkg::HI_NIB_MSB:rrf_pkg::HI_NIB_LSB] == rrf_pkg::OP_HI_FILL
            && instrWord[rrf_pkg::FILL_SEL_MSB:rrf_pkg::FILL_SEL_LSB] == rrf_pkg::OP_LO_FILL) begin
            decodedOp = rrf_pkg::OP_FILL;
        end
    end

    // A word is taken only in the decode phase while idle
    always_comb begin
        takeInstr   = 1'b0;
        rejectInstr = 1'b0;
        // Refused words leave the sequencer where it is
        if (phaseReg == rrf_pkg::PH_DECODE && !busy && instrValid) begin
            takeInstr   = (decodedOp != rrf_pkg::OP_NONE);
            rejectInstr = (decodedOp == rrf_pkg::OP_NONE);
        end
    end

    // Quarter phases: decode, read, process, write
    // Limitation: one instruction in flight, no overlap with the next fetch
    always_comb begin
        phaseNext = phaseReg;
        case (phaseReg)
            rrf_pkg::PH_DECODE: begin
                if (takeInstr) begin
                    phaseNext = rrf_pkg::PH_READ;
                end
            end
            rrf_pkg::PH_READ: begin
                phaseNext = rrf_pkg::PH_PROCESS;
            end
            rrf_pkg::PH_PROCESS: begin
                phaseNext = rrf_pkg::PH_WRITE;
            end
            rrf_pkg::PH_WRITE: begin
                phaseNext = rrf_pkg::PH_DECODE;
            end
            // Stray phase codes fall back to decode rather than lock up
            default: begin
                phaseNext = rrf_pkg::PH_DECODE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            phaseReg <= rrf_pkg::PH_DECODE;
        end else begin
            phaseReg <= phaseNext;
        end
    end

    // Busy spans read to write, so a word offered then is ignored
    always_ff @(posedge clk) begin
        if (rst) begin
            busy <= 1'b0;
        end else if (takeInstr) begin
            busy <= 1'b1;
        end else if (phaseReg == rrf_pkg::PH_WRITE) begin
            busy <= 1'b0;
        end
    end

    // Opcode and word are held; the inputs may move on after the take
    always_ff @(posedge clk) begin
        if (rst) begin
            opReg <= rrf_pkg::OP_NONE;
        end else if (takeInstr) begin
            opReg <= decodedOp;
        end
    end

    // Destination bit is read from the held word in the write phase
    always_ff @(posedge clk) begin
        if (rst) begin
            instrHoldReg <= 16'h0000;
        end else if (takeInstr) begin
            instrHoldReg <= instrWord;
        end
    end

    // Undecodable word: one pulse and nothing else
    always_ff @(posedge clk) begin
        if (rst) begin
            illegal <= 1'b0;
        end else begin
            illegal <= rejectInstr;
        end
    end

    // Bank-qualified address, held for read and write
    always_comb begin
        if (instrWord[rrf_pkg::A_BIT]) begin
            fileAddrNext = {bankSelectReg,
                            instrWord[rrf_pkg::ADDR_MSB:rrf_pkg::ADDR_LSB]};
        end else begin
            // Access bank ignores the bank select register entirely
            fileAddrNext = {rrf_pkg::ACCESS_BANK,
                            instrWord[rrf_pkg::ADDR_MSB:rrf_pkg::ADDR_LSB]};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fileAddr <= 12'h000;
        end else if (takeInstr) begin
            fileAddr <= fileAddrNext;
        end
    end

    // Operand read strobe in the read phase
    always_ff @(posedge clk) begin
        if (rst) begin
            fileRead <= 1'b0;
        end else begin
            fileRead <= takeInstr;
        end
    end

    // Memory answers in the strobe cycle, so capture on that edge
    always_ff @(posedge clk) begin
        if (rst) begin
            operandReg <= 8'h00;
        end else if (phaseReg == rrf_pkg::PH_READ) begin
            operandReg <= fileRdata;
        end
    end

    // Process phase: result and carry from the held operand
    always_comb begin
        resultNext   = operandReg;
        newCarryNext = carryFlag;
        case (opReg)
            rrf_pkg::OP_RRC: begin
                resultNext   = {carryFlag, operandReg[7:1]};
                newCarryNext = operandReg[0];
            end
            rrf_pkg::OP_RRN: begin
                resultNext = {operandReg[0], operandReg[7:1]};
            end
            rrf_pkg::OP_FILL: begin
                resultNext = rrf_pkg::FILL_VALUE;
            end
            // Unused opcodes pass the operand through unchanged
            default: begin
                resultNext = operandReg;
            end
        endcase
    end

    // Registered so the write phase sees a settled result
    always_ff @(posedge clk) begin
        if (rst) begin
            resultReg <= 8'h00;
        end else if (phaseReg == rrf_pkg::PH_PROCESS) begin
            resultReg <= resultNext;
        end
    end

    // Carry is committed only in the write phase
    always_ff @(posedge clk) begin
        if (rst) begin
            newCarryReg <= 1'b0;
        end else if (phaseReg == rrf_pkg::PH_PROCESS) begin
            newCarryReg <= newCarryNext;
        end
    end

    // Write-phase qualifiers
    always_comb begin
        inWrite      = (phaseReg == rrf_pkg::PH_WRITE);
        rotateOp     = (opReg == rrf_pkg::OP_RRC) || (opReg == rrf_pkg::OP_RRN);
        // Fill carries no destination bit; bit 9 belongs to its opcode
        destFile     = (opReg == rrf_pkg::OP_FILL) || instrHoldReg[rrf_pkg::D_BIT];
        resultIsZero = (resultReg == 8'h00);
    end

    // Destination steering
    always_ff @(posedge clk) begin
        if (rst) begin
            fileWrite <= 1'b0;
        end else begin
            fileWrite <= inWrite && destFile;
        end
    end

    // Write data holds until the next write
    always_ff @(posedge clk) begin
        if (rst) begin
            fileWdata <= 8'h00;
        end else if (inWrite && destFile) begin
            fileWdata <= resultReg;
        end
    end

    // Accumulator keeps its value when the file register is the target
    always_ff @(posedge clk) begin
        if (rst) begin
            accReg <= 8'h00;
        end else if (inWrite && !destFile) begin
            accReg <= resultReg;
        end
    end

    // Completion pulse registered from the write phase, high in the cycle after it
    always_ff @(posedge clk) begin
        if (rst) begin
            done <= 1'b0;
        end else begin
            done <= inWrite;
        end
    end

    // Carry moves only for rotate-through-carry; plain rotate and fill keep it
    always_ff @(posedge clk) begin
        if (rst) begin
            carryFlag <= 1'b0;
        end else if (inWrite && (opReg == rrf_pkg::OP_RRC)) begin
            carryFlag <= newCarryReg;
        end
    end

    // Negative and zero follow either rotate; fill leaves them alone
    always_ff @(posedge clk) begin
        if (rst) begin
            negFlag <= 1'b0;
        end else if (inWrite && rotateOp) begin
            negFlag <= resultReg[7];
        end
    end

    // Zero compare is made once, in the qualifier block
    always_ff @(posedge clk) begin
        if (rst) begin
            zeroFlag <= 1'b0;
        end else if (inWrite && rotateOp) begin
            zeroFlag <= resultIsZero;
        end
    end
endmodule

/* File: rrf_exec_chk.sv */
`timescale 1ns/1ps
module rrf_exec_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Instruction side
    input wire logic        instrValid,
    input wire logic [15:0] instrWord,
    input wire logic [3:0]  bankSelectReg,
    input wire logic [7:0]  fileRdata,
    // Results
    input wire logic [11:0] fileAddr,
    input wire logic        fileRead,
    input wire logic        fileWrite,
    input wire logic [7:0]  fileWdata,
    input wire logic [7:0]  accReg,
    input wire logic        carryFlag,
    input wire logic        negFlag,
    input wire logic        zeroFlag,
    input wire logic        busy,
    input wire logic        done,
    input wire logic        illegal
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic rdLsb;
    assign rdLsb = fileRdata[0];
    sequence takeRrc;
        instrValid && !busy && instrWord[15:10] == 6'h0c;
    endsequence
    sequence takeFill;
        instrValid && !busy && instrWord[15:9] == 7'h34;
    endsequence
    sequence takeRrn;
        instrValid && !busy && instrWord[15:10] == 6'h10;
    endsequence
    chk_read_on_take: assert property ($rose(busy) |-> fileRead)
        else $error("operand read missing at start");
    chk_done_bound: assert property ($rose(busy) |-> ##[2:4] done)
        else $error("instruction did not complete in time");
    chk_read_pulse: assert property (fileRead |=> !fileRead)
        else $error("operand read longer than one cycle");
    chk_bank_addr: assert property ($rose(busy) |-> fileAddr ==
        {$past(instrWord[8]) ? $past(bankSelectReg) : 4'h0, $past(instrWord[7:0])})
        else $error("wrong file address");
    chk_fill_write: assert property (takeFill |-> ##[3:5] (fileWrite && fileWdata == 8'hff))
        else $error("fill did not write all ones");
    chk_fill_flags: assert property (takeFill |=> $stable({carryFlag, negFlag, zeroFlag})[*5])
        else $error("fill changed a flag");
    chk_plain_carry: assert property (takeRrn |=> $stable(carryFlag)[*5])
        else $error("plain rotate changed carry");
    chk_acc_flags: assert property (done && !fileWrite |->
        negFlag == accReg[7] && zeroFlag == (accReg == 8'h00))
        else $error("flags disagree with result");
    chk_rrc_carry: assert property (takeRrc |-> ##4 (carryFlag == $past(rdLsb, 3)))
        else $error("carry did not take old bit 0");
    chk_rrc_msb: assert property (takeRrc |->
        ##4 (done && (fileWrite ? fileWdata[7] : accReg[7]) == $past(carryFlag, 4)))
        else $error("old carry not rotated into bit 7");
    chk_illegal_quiet: assert property (illegal |-> !fileRead && !busy)
        else $error("undecodable word started a cycle");
    chk_acc_keep: assert property (done && fileWrite |-> $stable(accReg))
        else $error("accumulator changed on a file write");
endmodule
bind rrf_exec rrf_exec_chk i_rrf_exec_chk (
    .clk(clk), .rst(rst), .instrValid(instrValid), .instrWord(instrWord),
    .bankSelectReg(bankSelectReg), .fileRdata(fileRdata), .fileAddr(fileAddr),
    .fileRead(fileRead), .fileWrite(fileWrite), .fileWdata(fileWdata), .accReg(accReg),
    .carryFlag(carryFlag), .negFlag(negFlag), .zeroFlag(zeroFlag), .busy(busy),
    .done(done), .illegal(illegal));

/* File: rrf_exec_tb_top.sv */
`timescale 1ns/1ps
module rrf_exec_tb_top;
    typedef struct packed {
        logic [15:0] w;
        logic [3:0]  b;
        logic [7:0]  r;
        logic [7:0]  res;
        logic        c, n, z;
    } rrf_row_s;
    logic        clk, rst, instrValid, fileRead, fileWrite, carryFlag, negFlag, zeroFlag;
    logic        busy, done, illegal;
    logic [15:0] instrWord;
    logic [3:0]  bankSelectReg;
    logic [11:0] fileAddr;
    logic [7:0]  fileRdata, fileWdata, accReg;
    int          compares, miscompares, cyc;
    // Carry chains from row to row, so order matters
    rrf_row_s rows [8] = '{
        '{16'h3012, 4'h5, 8'hd7, 8'h6b, 1'h1, 1'h0, 1'h0},
        '{16'h3334, 4'ha, 8'h01, 8'h80, 1'h1, 1'h1, 1'h0},
        '{16'h4256, 4'h0, 8'hd7, 8'heb, 1'h1, 1'h1, 1'h0},
        '{16'h4178, 4'h3, 8'h00, 8'h00, 1'h1, 1'h0, 1'h1},
        '{16'h309a, 4'h0, 8'h00, 8'h80, 1'h0, 1'h1, 1'h0},
        '{16'h30bc, 4'h0, 8'h00, 8'h00, 1'h0, 1'h0, 1'h1},
        '{16'h69de, 4'hc, 8'h55, 8'hff, 1'h0, 1'h0, 1'h1},
        '{16'h6801, 4'h7, 8'h55, 8'hff, 1'h0, 1'h0, 1'h1}};
    rrf_exec i_rrf_exec (.clk(clk), .rst(rst), .instrValid(instrValid), .instrWord(instrWord),
        .bankSelectReg(bankSelectReg), .fileAddr(fileAddr), .fileRead(fileRead),
        .fileRdata(fileRdata), .fileWrite(fileWrite), .fileWdata(fileWdata), .accReg(accReg),
        .carryFlag(carryFlag), .negFlag(negFlag), .zeroFlag(zeroFlag), .busy(busy),
        .done(done), .illegal(illegal));
    always #10 clk = ~clk;
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic issue(input logic [15:0] w, input logic [3:0] b, input logic [7:0] r);
        @(posedge clk);
        instrValid <= 1'h1;
        instrWord <= w;
        bankSelectReg <= b;
        fileRdata <= r;
        @(posedge clk);
        instrValid <= 1'h0;
        #1;
    endtask
    task automatic run(input rrf_row_s t);
        int  n;
        logic toFile;
        toFile = t.w[9] | (t.w[15:12] == 4'h6);
        issue(t.w, t.b, t.r);
        check("read", fileRead, 1'h1);
        check("addr", fileAddr, {t.w[8] ? t.b : 4'h0, t.w[7:0]});
        n = 0;
        while (done !== 1'h1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("done", done, 1'h1);
        check("cycles", 16'(n), 16'h3);
        check("write", fileWrite, toFile);
        check("result", toFile ? fileWdata : accReg, t.res);
        check("flags", {carryFlag, negFlag, zeroFlag}, {t.c, t.n, t.z});
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            miscompares++;
            test_done;
        end
    end
    initial begin
        {clk, instrValid, instrWord, bankSelectReg, fileRdata} = '0;
        rst = 1'h1;
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        #1;
        check("reset", {accReg, carryFlag, busy, done}, 16'h0);
        foreach (rows[i]) run(rows[i]);
        // Undecodable word must leave the file untouched
        issue(16'h5000, 4'h1, 8'h3c);
        check("illegal", {illegal, fileRead}, 16'h2);
        // Reset cuts an instruction in flight; the cut write must never land
        issue(16'h3201, 4'h0, 8'h81);
        @(posedge clk);
        rst <= 1'h1;
        @(posedge clk);
        #1;
        check("midreset", {accReg, zeroFlag, busy, fileWrite, done}, 16'h0);
        @(posedge clk);
        rst <= 1'h0;
        #1;
        check("held", {carryFlag, negFlag, zeroFlag, busy}, 16'h0);
        run(rows[0]);
        test_done;
    end
endmodule

/* File: rrf_pkg.sv */
package rrf_pkg;
    // Opcode upper-byte fields
    localparam logic [3:0] OP_HI_RRC     = 4'h3;
    localparam logic [3:0] OP_HI_RRN     = 4'h4;
    localparam logic [3:0] OP_HI_FILL    = 4'h6;
    localparam logic [1:0] OP_LO_ROT     = 2'h0;
    localparam logic [2:0] OP_LO_FILL    = 3'h4;
    localparam int         HI_NIB_MSB    = 15;
    localparam int         HI_NIB_LSB    = 12;
    localparam int         ROT_SEL_MSB   = 11;
    localparam int         ROT_SEL_LSB   = 10;
    localparam int         FILL_SEL_MSB  = 11;
    localparam int         FILL_SEL_LSB  = 9;
    localparam int         D_BIT         = 9;
    localparam int         A_BIT         = 8;
    localparam int         ADDR_MSB      = 7;
    localparam int         ADDR_LSB      = 0;
    localparam logic [7:0] FILL_VALUE    = 8'hff;
    localparam logic [3:0] ACCESS_BANK   = 4'h0;
    localparam logic [1:0] DEST_ACC      = 2'h0;
    // Quarter phases of one instruction cycle
    typedef enum logic [1:0] {
        PH_DECODE,
        PH_READ,
        PH_PROCESS,
        PH_WRITE
    } rrf_phase_e;
    typedef enum logic [1:0] {
        OP_NONE,
        OP_RRC,
        OP_RRN,
        OP_FILL
    } rrf_op_e;
endpackage
